// file: rtl/pvs_cfg.svh
// Functional notes
// - the lock bit reads 1 while the analog pll is locked and 0 while it is unlocked.
// - bit 2 of the pll status shows the rail-high indication live, without latching.
// - bit 1 of the pll status shows the rail-low indication live.
// - calibration done at bit 6 reads 0 while band calibration runs and 1 once it has finished.
// - calibration fail at bit 7 reads 1 on a failed calibration, and counts only once done is set.
// - the 6-bit band field shows the band picked by calibration, valid only after done reads 1.
// - the coarse trim field resets to 1 and mirrors the configured trim while trim calibration is off.
// - while trim calibration is on, the coarse trim field shows the trim chosen by calibration.
// - bits 6..0 of the spare register show the regulator detector result of banks 6..0.
// - bits 15..7 of the spare register are unused analog spare inputs and reset to zero.
`ifndef PVS_CFG_SVH
`define PVS_CFG_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PVS_OFF_PLL 4'h0
`define PVS_OFF_CAL 4'h4
`define PVS_OFF_TRIM 4'h8
`define PVS_OFF_SPARE 4'hc
`define PVS_OFF_INT_STATUS 4'h0
`define PVS_OFF_INT_CLEAR 4'h4
`define PVS_OFF_INT_ENABLE 4'h8
`define PVS_OFF_TRIM_CFG 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define PVS_LOCK_BIT 0
`define PVS_RAIL_LOW_BIT 1
`define PVS_RAIL_HIGH_BIT 2
`define PVS_CAL_DONE_BIT 6
`define PVS_CAL_FAIL_BIT 7
`define PVS_BANK_COUNT 7
`define PVS_SPARE_WIDTH 9

// ----------------------------------------
// reset values
// ----------------------------------------
`define PVS_TRIM_RESET 2'h1
`define PVS_READ_UNMAPPED 32'h0000_0000

`endif

// file: rtl/pvs_pkg.sv
package pvs_pkg;
  // which register group the bus address selects
  typedef enum logic {
    pvs_page_status,
    pvs_page_control
  } pvs_page_t;
  // interrupt event positions: lock change, cal done, cal fail, rail
  typedef logic [3:0] pvs_events_t;
endpackage

// file: rtl/pvs_status_regs.sv
`timescale 1ns/1ps
`include "pvs_cfg.svh"

module pvs_status_regs (
  input wire logic clock,
  input wire logic reset,
  // avalon-mm slave, byte address bit 4 picks the page
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // analog and calibration indications
  input wire logic pll_locked,
  input wire logic pll_rail_high,
  input wire logic pll_rail_low,
  input wire logic cal_done,
  input wire logic cal_fail,
  input wire logic [5:0] cal_band,
  input wire logic trim_cal_enable,
  input wire logic [1:0] cal_trim,
  input wire logic [`PVS_BANK_COUNT-1:0] bank_regulator_detect,
  input wire logic [`PVS_SPARE_WIDTH-1:0] analog_spare,
  // configured coarse trim, a software register here
  output logic [1:0] coarse_trim
);
  import pvs_pkg::*;

  logic [7:0] pll_status;
  logic [7:0] vco_calibration_status;
  logic [7:0] vco_coarse_trim_status;
  logic [15:0] spare_and_bank_voltage_status;
  pvs_events_t int_status;
  pvs_events_t int_enable;
  pvs_events_t event_hits;
  logic prev_locked;
  logic prev_done;
  logic prev_fail;
  logic prev_rail;
  logic served;
  logic access;
  logic write_taken;
  pvs_page_t page;
  logic [3:0] offset;
  logic [31:0] next_readdata;

  assign access = (read | write) & ~served;
  // a write lands only on the edge where the master sees waitrequest low, never while it still waits
  assign write_taken = write & ~waitrequest;
  assign page = address[4] ? pvs_page_control : pvs_page_status;
  assign offset = {address[3:2], 2'b00};

  // ----------------------------------------
  // status sampling
  // ----------------------------------------
  // one flop of sampling keeps the bus mux off the raw analog wires
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pll_status <= 8'h00;
    end else begin
      pll_status <= 8'h00; // reserved bits stay zero
      pll_status[`PVS_LOCK_BIT] <= pll_locked;
      pll_status[`PVS_RAIL_LOW_BIT] <= pll_rail_low;
      pll_status[`PVS_RAIL_HIGH_BIT] <= pll_rail_high;
    end
  end

  // band and fail pass through as given; they mean something only once done is set
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      vco_calibration_status <= 8'h00;
    end else begin
      vco_calibration_status <= {cal_fail, cal_done, cal_band};
    end
  end

  // trim source flips with the calibration enable
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      vco_coarse_trim_status <= {6'h00, `PVS_TRIM_RESET};
    end else if (trim_cal_enable) begin
      vco_coarse_trim_status <= {6'h00, cal_trim};
    end else begin
      vco_coarse_trim_status <= {6'h00, coarse_trim};
    end
  end

  // spare bits carry no function but are still readable
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      spare_and_bank_voltage_status <= 16'h0000;
    end else begin
      spare_and_bank_voltage_status <= {analog_spare, bank_regulator_detect};
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_locked <= 1'b0;
      prev_done <= 1'b0;
      prev_fail <= 1'b0;
      prev_rail <= 1'b0;
    end else begin
      prev_locked <= pll_status[`PVS_LOCK_BIT];
      prev_done <= vco_calibration_status[`PVS_CAL_DONE_BIT];
      prev_fail <= vco_calibration_status[`PVS_CAL_FAIL_BIT];
      prev_rail <= pll_status[`PVS_RAIL_HIGH_BIT] | pll_status[`PVS_RAIL_LOW_BIT];
    end
  end

  // bit0 lock change, bit1 done rise, bit2 fail rise, bit3 rail rise
  assign event_hits = {
    (pll_status[`PVS_RAIL_HIGH_BIT] | pll_status[`PVS_RAIL_LOW_BIT]) & ~prev_rail,
    vco_calibration_status[`PVS_CAL_FAIL_BIT] & ~prev_fail,
    vco_calibration_status[`PVS_CAL_DONE_BIT] & ~prev_done,
    pll_status[`PVS_LOCK_BIT] ^ prev_locked
  };

  // a new event beats a clear in the same cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      int_status <= 4'h0;
    end else if (write_taken && page == pvs_page_control && offset == `PVS_OFF_INT_CLEAR && byteenable[0]) begin
      int_status <= (int_status & ~writedata[3:0]) | event_hits;
    end else begin
      int_status <= int_status | event_hits;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end

  // ----------------------------------------
  // writable control
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      int_enable <= 4'h0;
      coarse_trim <= `PVS_TRIM_RESET;
    end else if (write_taken && page == pvs_page_control && byteenable[0]) begin
      // status page writes never reach here
      if (offset == `PVS_OFF_INT_ENABLE) begin
        int_enable <= writedata[3:0];
      end
      if (offset == `PVS_OFF_TRIM_CFG) begin
        coarse_trim <= writedata[1:0];
      end
    end
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  always_comb begin
    next_readdata = `PVS_READ_UNMAPPED;
    unique case (page)
      pvs_page_status: begin
        unique case (offset)
          `PVS_OFF_PLL: next_readdata = {24'h0, pll_status};
          `PVS_OFF_CAL: next_readdata = {24'h0, vco_calibration_status};
          `PVS_OFF_TRIM: next_readdata = {24'h0, vco_coarse_trim_status};
          default: next_readdata = {16'h0, spare_and_bank_voltage_status};
        endcase
      end
      pvs_page_control: begin
        unique case (offset)
          `PVS_OFF_INT_STATUS: next_readdata = {28'h0, int_status};
          `PVS_OFF_INT_ENABLE: next_readdata = {28'h0, int_enable};
          `PVS_OFF_TRIM_CFG: next_readdata = {30'h0, coarse_trim};
          default: next_readdata = `PVS_READ_UNMAPPED; // clear register is write-only
        endcase
      end
    endcase
  end

  // one wait cycle: waitrequest drops the cycle after a request shows up
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      served <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      served <= access;
      waitrequest <= ~access;
      if (access && read) begin
        readdata <= next_readdata;
      end
    end
  end
endmodule

// file: verif/pvs_status_regs_checker.sv
`timescale 1ns/1ps
// bus answer timing and status page readback
module pvs_status_regs_checker (
  input wire logic clock, reset, read, write, waitrequest,
  input wire logic [4:0] address,
  input wire logic [31:0] readdata,
  input wire logic pll_locked, pll_rail_high, pll_rail_low, cal_done, cal_fail, trim_cal_enable,
  input wire logic [5:0] cal_band,
  input wire logic [1:0] cal_trim, coarse_trim,
  input wire logic [6:0] bank_regulator_detect,
  input wire logic [8:0] analog_spare
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // pins reach a status flop one edge later and readdata one edge after that
  sequence served;
    !waitrequest ##1 waitrequest;
  endsequence
  wait_one_a: assert property ((read || write) && waitrequest |=> served) else $error("bus answer not one cycle");
  idle_wait_a: assert property (!(read || write) |=> waitrequest) else $error("answer without request");
  pll_rd_a: assert property (read && !waitrequest && address == 5'h00 |->
    readdata == {29'h0, $past(pll_rail_high, 2), $past(pll_rail_low, 2), $past(pll_locked, 2)})
    else $error("pll status readback wrong");
  cal_rd_a: assert property (read && !waitrequest && address == 5'h04 |->
    readdata == {24'h0, $past(cal_fail, 2), $past(cal_done, 2), $past(cal_band, 2)})
    else $error("calibration status readback wrong");
  trim_rd_a: assert property (read && !waitrequest && address == 5'h08 |->
    readdata == {30'h0, $past(trim_cal_enable, 2) ? $past(cal_trim, 2) : $past(coarse_trim, 2)})
    else $error("trim status readback wrong");
  spare_rd_a: assert property (read && !waitrequest && address == 5'h0c |->
    readdata == {16'h0, $past(analog_spare, 2), $past(bank_regulator_detect, 2)})
    else $error("spare status readback wrong");
  clr_rd_a: assert property (read && !waitrequest && address == 5'h14 |-> readdata == 32'h0)
    else $error("clear register not zero");
  trim_cfg_a: assert property (!$stable(coarse_trim) |-> $past(write) && $past(address) == 5'h1c)
    else $error("coarse trim moved without its write");
endmodule

bind pvs_status_regs pvs_status_regs_checker chk_u (.*);

// file: verif/pvs_status_regs_tb.sv
`timescale 1ns/1ps
module pvs_status_regs_tb;
  logic clock = 0, reset = 1, read = 0, write = 0, irq, waitrequest, pll_locked = 0, pll_rail_high = 0;
  logic pll_rail_low = 0, cal_done = 0, cal_fail = 0, trim_cal_enable = 0;
  logic [1:0] cal_trim = 0, coarse_trim, cfg = 2'h1;
  logic [3:0] byteenable = 4'hf;
  logic [4:0] address = 0;
  logic [5:0] cal_band = 0;
  logic [6:0] bank_regulator_detect = 0;
  logic [8:0] analog_spare = 0;
  logic [31:0] writedata = 0, readdata, d, lf, st = 32'ha4d383cb;
  int fails = 0, cmp_count = 0;
  pvs_status_regs dut_u (.*);
  always #20 clock = ~clock;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected status word from the pins the bench drives
  function automatic logic [31:0] ex(input logic [4:0] a);
    case (a)
      5'h00: return {29'h0, pll_rail_high, pll_rail_low, pll_locked};
      5'h04: return {24'h0, cal_fail, cal_done, cal_band};
      5'h08: return {30'h0, trim_cal_enable ? cal_trim : cfg};
      default: return {16'h0, analog_spare, bank_regulator_detect};
    endcase
  endfunction
  task chk(input string n, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= wd;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 0;
    write <= 0;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  task rise_done;
    @(posedge clock) cal_done <= 0;
    wait_n(3);
    cal_done <= 1;
    wait_n(4);
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    wait_n(3);
    reset <= 0;
    for (int a = 0; a < 16; a += 4) begin
      bus(0, a[4:0], 0);
      chk("reset status", d, a == 8 ? 32'h1 : 32'h0);
    end
    $display("reset values done");
    // first pass is the all-ones corner, the rest random
    for (int i = 0; i < 24; i++) begin
      lf = i == 0 ? 32'hffff_ffff : st;
      st = nx(st);
      @(posedge clock);
      {pll_locked, pll_rail_high, pll_rail_low, cal_done, cal_fail, cal_band} <= lf[10:0];
      {trim_cal_enable, cal_trim, bank_regulator_detect, analog_spare} <= lf[29:11];
      cfg = lf[31:30];
      bus(1, 5'h1c, {30'h0, cfg});
      bus(1, {1'b0, lf[5:4], 2'b00}, ~lf);
      wait_n(3);
      chk("coarse_trim", {30'h0, coarse_trim}, {30'h0, cfg});
      for (int a = 0; a < 16; a += 4) begin
        bus(0, a[4:0], 0);
        chk("status", d, ex(a[4:0]));
      end
    end
    $display("status readback done");
    @(posedge clock) cal_done <= 0;
    wait_n(3);
    bus(1, 5'h14, 32'hf);
    bus(1, 5'h18, 32'h2);
    bus(0, 5'h18, 0);
    chk("int_enable", d, 32'h2);
    rise_done;
    chk("irq raised", irq, 1);
    bus(0, 5'h10, 0);
    chk("int_status", d[1], 1);
    bus(1, 5'h14, 32'h2);
    wait_n(3);
    chk("irq cleared", irq, 0);
    bus(1, 5'h18, 0);
    rise_done;
    chk("irq masked", irq, 0);
    bus(0, 5'h10, 0);
    chk("int_status masked", d[1], 1);
    bus(1, 5'h14, 32'hf);
    pll_locked <= ~pll_locked;
    wait_n(3);
    bus(0, 5'h10, 0);
    chk("lock event", d, 32'h1);
    bus(0, 5'h14, 0);
    chk("clear reads zero", d, 32'h0);
    $display("interrupt done");
    results;
  end
  initial begin
    wait_n(5000);
    fails++;
    results;
  end
endmodule
